// file: verilog/cuf_regs.svh
// cuf_regs.svh: register indices, field positions, reset values and counts for the
// smart card uart data path.
// assumes: included by bare name; definitions only.
`ifndef CUF_REGS_SVH
`define CUF_REGS_SVH

// ----------------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define CUF_IDX_TX_DATA   16'hfe07
`define CUF_IDX_RX_STAT   16'hfe08
`define CUF_IDX_RX_DATA   16'hfe09
`define CUF_IDX_CTRL      16'hfe10
`define CUF_IDX_ETU       16'hfe11
`define CUF_IDX_IRQ_STAT  16'hfe12
`define CUF_IDX_IRQ_MASK  16'hfe13

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CUF_ST_NINTH      7
`define CUF_ST_FINAL      5
`define CUF_ST_CHKERR     4
`define CUF_ST_FULL       3
`define CUF_ST_EMPTY      2
`define CUF_ST_OVR        1
`define CUF_ST_PAR        0
`define CUF_CT_DIR        0
`define CUF_CT_SYNC       1
`define CUF_CT_NINE       2
`define CUF_CT_CRC        3
`define CUF_IR_RXBYTE     0
`define CUF_IR_RX_ERROR_EVENT      1
`define CUF_IR_CHKERR     2

// ----------------------------------------------------------------------------
// reset values, check constants and counts
// ----------------------------------------------------------------------------
`define CUF_RST_BYTE      8'h00
`define CUF_RST_ETU       12'h174
`define CUF_CRC_INIT      16'hffff
`define CUF_CRC_POLY      16'h1021
`define CUF_CRC_GOOD      16'h1d0f
`define CUF_LRC_GOOD      8'h00
`define CUF_TX_DEPTH      2
`define CUF_RX_DEPTH      4
`define CUF_IDX_START     4'h0
`define CUF_IDX_DATA0     4'h1
`define CUF_IDX_DATA7     4'h8
`define CUF_IDX_NINTH     4'h9
`define CUF_TX_ASYNC_BITS 4'hb
`define CUF_TX_SYNC_BITS  4'h8

`endif

// file: verilog/cuf_pkg.sv
// cuf_pkg.sv: types of the smart card uart data path.
// assumes: cuf_regs.svh holds every number but the state encodings below.
`default_nettype none
package cuf_pkg;
  // link engine states, one-hot
  typedef enum logic [2:0] {
    CUF_IDLE = 3'b001,
    CUF_RX   = 3'b010,
    CUF_TX   = 3'b100
  } cuf_state_t;
endpackage : cuf_pkg
`default_nettype wire

// file: verilog/cuf_queue_if.sv
// cuf_queue_if.sv: byte queue connection between the uart top and its queues.
// assumes: one clock domain, pclk.
`timescale 1ns/1ps
`default_nettype none
interface cuf_queue_if;
  logic       push;
  logic [7:0] push_data;
  logic       pop;
  logic [7:0] head;
  logic       full;
  logic       empty;
  modport user  (output push, output push_data, output pop,
                 input head, input full, input empty);
  modport store (input push, input push_data, input pop,
                 output head, output full, output empty);
endinterface : cuf_queue_if
`default_nettype wire

// file: verilog/cuf_queue.sv
// cuf_queue.sv: byte queue in flip-flops with wrap-bit pointers.
// assumes: caller never pushes when full nor pops when empty.
`timescale 1ns/1ps
`default_nettype none
`include "cuf_regs.svh"
module cuf_queue #(
  parameter int DEPTH = 2
) (
  input wire logic   pclk,
  input wire logic   presetn,
  cuf_queue_if.store q
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [7:0]  mem_r [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;

  // ----------------------------------------------------------------------------
  // pointer compare
  // ----------------------------------------------------------------------------
  // the wrap bit tells full from empty when the index parts agree
  wire ptr_same = (wr_r[AW-1:0] == rd_r[AW-1:0]);
  assign q.empty = ptr_same && (wr_r[AW] == rd_r[AW]);
  assign q.full  = ptr_same && (wr_r[AW] != rd_r[AW]);
  assign q.head  = mem_r[rd_r[AW-1:0]];

  // storage is never cleared by a pop; only a later push replaces a byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= `CUF_RST_BYTE;
      end
    end else if (q.push) begin
      mem_r[wr_r[AW-1:0]] <= q.push_data;
    end
  end

  // pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (q.push) wr_r <= wr_r + 1'b1;
      if (q.pop)  rd_r <= rd_r + 1'b1;
    end
  end
endmodule : cuf_queue
`default_nettype wire

// file: verilog/cuf_uart.sv
// cuf_uart.sv: smart card uart data path with receive status, apb registers and irq.
// assumes: card clock and card io arrive from outside pclk; io is open drain.
//
// Functional notes
// R1: a write to the transmit data port pushes the byte into the transmit queue for sending.
// R2: a read of the transmit data port consumes one entry, so two reads leave it empty.
// R3: consuming entries does not erase stored bytes; only later writes replace them.
// R4: in sync 9-bit mode the io level at the ninth rising card clock is kept as the ninth bit.
// R5: with the final byte flag set, a completed byte checks crc residue or lrc, else error.
// R6: a read-only check error flag shows one once a block-end mismatch was found.
// R7: a read-only receive full flag is one while the receive queue is at its depth.
// R8: the read-only receive empty flag is status only and raises no interrupt.
// R9: a byte arriving with the receive queue full sets overrun, cleared by read, with an irq.
// R10: while overrun is set every received byte is dropped.
// R11: a parity failure sets the parity flag, cleared by read, with a receive error irq.
// R12: received bytes go to the receive queue and each data port read gives the oldest.
// R13: the transmit data, receive status and receive data registers are 8 bits, reset zero except the receive empty flag, which resets to one.
// R14: writing the direction field restarts the checksum accumulator.
// R15: queue depths are parameters; full and empty come from pointer compare.
`timescale 1ns/1ps
`default_nettype none
`include "cuf_regs.svh"
module cuf_uart
  import cuf_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        card_clk,
  input  wire logic        ext_card_io_in,
  output var  logic        ext_card_io_out,
  output var  logic        ext_card_io_oe_n,
  output var  logic        irq
);
  // ----------------------------------------------------------------------------
  // checksum helper
  // ----------------------------------------------------------------------------
  function automatic logic [15:0] cuf_crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ `CUF_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : cuf_crc_byte

  // ----------------------------------------------------------------------------
  // queues
  // ----------------------------------------------------------------------------
  cuf_queue_if txq ();
  cuf_queue_if rxq ();
  cuf_queue #(.DEPTH(`CUF_TX_DEPTH)) u_txq (.pclk(pclk), .presetn(presetn), .q(txq)); // see R15
  cuf_queue #(.DEPTH(`CUF_RX_DEPTH)) u_rxq (.pclk(pclk), .presetn(presetn), .q(rxq)); // see R15

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  logic       clk_s1_r, clk_s2_r, clk_d_r, io_s1_r, io_s2_r;
  logic [3:0] ctrl_r;
  logic [11:0] etu_r;
  logic [11:0] etu_cnt_r;
  logic       ninth_r, final_r, chkerr_r, ovr_r, par_r;
  logic [2:0] ist_r, imask_r;
  logic [15:0] crc_r;
  logic [7:0] lrc_r;
  cuf_state_t st_r;
  logic [3:0] bit_r;
  logic [7:0] shf_r;
  logic [10:0] txs_r;
  logic [31:0] rdat_r;

  // ----------------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------------
  wire [15:0] idx      = paddr[17:2];
  wire        setup    = psel && !penable;
  wire        acc      = psel && penable && pready;
  wire        sel_txd  = (idx == `CUF_IDX_TX_DATA);
  wire        sel_st   = (idx == `CUF_IDX_RX_STAT);
  wire        sel_rxd  = (idx == `CUF_IDX_RX_DATA);
  wire        sel_ct   = (idx == `CUF_IDX_CTRL);
  wire        sel_etu  = (idx == `CUF_IDX_ETU);
  wire        sel_ist  = (idx == `CUF_IDX_IRQ_STAT);
  wire        sel_im   = (idx == `CUF_IDX_IRQ_MASK);
  wire        mapped   = sel_txd | sel_st | sel_rxd | sel_ct | sel_etu | sel_ist | sel_im;
  wire        wr_acc   = acc && pwrite && mapped;
  wire        rd_acc   = acc && !pwrite && mapped;
  wire        dir_tx   = ctrl_r[`CUF_CT_DIR];
  wire        sync_m   = ctrl_r[`CUF_CT_SYNC];
  wire        nine_m   = ctrl_r[`CUF_CT_NINE];
  wire        crc_m    = ctrl_r[`CUF_CT_CRC];

  // receive status byte as software sees it
  wire [7:0] stat_view = {ninth_r, 1'b0, final_r, chkerr_r,
                          rxq.full, rxq.empty, ovr_r, par_r}; // see R7, R8

  // read mux; captured at setup so prdata comes from a flop
  wire [7:0] rd_mux = sel_txd ? txq.head :
                      sel_st  ? stat_view :
                      sel_rxd ? rxq.head :
                      sel_ct  ? {4'h0, ctrl_r} :
                      sel_ist ? {5'h00, ist_r} :
                      sel_im  ? {5'h00, imask_r} : 8'h00;
  wire [31:0] rd_word = sel_etu ? {20'h0_0000, etu_r} : {24'h00_0000, rd_mux};

  // ----------------------------------------------------------------------------
  // link sampling: two flops, then an edge detector on the second
  // ----------------------------------------------------------------------------
  wire rise     = clk_s2_r && !clk_d_r;
  wire etu_zero = (etu_cnt_r == 12'h000);
  wire tick     = rise && (sync_m || etu_zero);
  wire rx_go    = (st_r == CUF_IDLE) && !dir_tx && rise && (sync_m || !io_s2_r);
  wire samp     = (st_r == CUF_RX) && tick;
  wire [3:0] last_idx = (sync_m && !nine_m) ? `CUF_IDX_DATA7 : `CUF_IDX_NINTH;
  wire false_st = samp && !sync_m && (bit_r == `CUF_IDX_START) && io_s2_r;
  wire byte_end = samp && (bit_r == last_idx);
  // sync 8-bit mode finishes on the eighth data bit, so include it in the byte
  wire [7:0] rx_byte = (bit_r == `CUF_IDX_DATA7) ? {io_s2_r, shf_r[7:1]} : shf_r;
  wire par_bad  = byte_end && !sync_m && ((^rx_byte) ^ io_s2_r);
  wire store    = byte_end && !rxq.full && !ovr_r; // see R10
  wire ovr_set  = byte_end && rxq.full && !ovr_r;  // see R9
  wire [15:0] crc_nxt = cuf_crc_byte(crc_r, rx_byte);
  wire [7:0]  lrc_nxt = lrc_r ^ rx_byte;
  wire chk_bad  = byte_end && final_r &&
                  (crc_m ? (crc_nxt != `CUF_CRC_GOOD) : (lrc_nxt != `CUF_LRC_GOOD)); // see R5
  // the line is shared, so a receive start wins over a pending transmit
  wire tx_go    = (st_r == CUF_IDLE) && dir_tx && !txq.empty && !rx_go;
  wire [3:0] tx_bits = sync_m ? `CUF_TX_SYNC_BITS : `CUF_TX_ASYNC_BITS;

  // read side effects only on what the captured word showed, so a flag raised
  // between setup and access is kept for the next read
  wire rd_st    = rd_acc && sel_st;
  wire clr_ovr  = rd_st && rdat_r[`CUF_ST_OVR];
  wire clr_par  = rd_st && rdat_r[`CUF_ST_PAR];
  wire [2:0] ev = {chk_bad, ovr_set | par_bad, store}; // receive empty is no event, see R8

  // queue connections
  assign txq.push      = wr_acc && sel_txd && !txq.full;         // see R1
  assign txq.push_data = pwdata[7:0];
  assign txq.pop       = (rd_acc && sel_txd && !txq.empty) || tx_go; // see R2, R3
  assign rxq.push      = store;                                   // see R12
  assign rxq.push_data = rx_byte;
  assign rxq.pop       = rd_acc && sel_rxd && !rxq.empty;         // see R12

  // ----------------------------------------------------------------------------
  // apb answer: no wait state, every output from a flop
  // ----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      rdat_r  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup) rdat_r <= mapped ? rd_word : 32'h0000_0000;
    end
  end
  assign prdata = rdat_r;

  // synchronisers for the link pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_s1_r <= 1'b0;
      clk_s2_r <= 1'b0;
      clk_d_r  <= 1'b0;
      io_s1_r  <= 1'b1;
      io_s2_r  <= 1'b1;
    end else begin
      clk_s1_r <= card_clk;
      clk_s2_r <= clk_s1_r;
      clk_d_r  <= clk_s2_r;
      io_s1_r  <= ext_card_io_in;
      io_s2_r  <= io_s1_r;
    end
  end

  // software control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= 4'h0;
      etu_r   <= `CUF_RST_ETU;
      imask_r <= 3'h0;
      final_r <= 1'b0;
    end else if (wr_acc) begin
      if (sel_ct)  ctrl_r  <= pwdata[3:0];
      if (sel_etu) etu_r   <= pwdata[11:0];
      if (sel_im)  imask_r <= pwdata[2:0];
      if (sel_st)  final_r <= pwdata[`CUF_ST_FINAL];
    end
  end

  // receive flags: hardware set wins over a read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_r    <= 1'b0;
      par_r    <= 1'b0;
      chkerr_r <= 1'b0;
      ninth_r  <= 1'b0;
    end else begin
      ovr_r <= ovr_set | (ovr_r & ~clr_ovr);   // see R9, R10
      par_r <= par_bad | (par_r & ~clr_par);   // see R11
      // cleared only when a new block starts checking
      chkerr_r <= chk_bad | (chkerr_r & ~(wr_acc && sel_ct)); // see R6
      if (byte_end && sync_m && nine_m) ninth_r <= io_s2_r; // see R4
    end
  end

  // checksum accumulators
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_r <= `CUF_CRC_INIT;
      lrc_r <= `CUF_LRC_GOOD;
    end else if (wr_acc && sel_ct) begin
      crc_r <= `CUF_CRC_INIT;   // see R14
      lrc_r <= `CUF_LRC_GOOD;   // see R14
    end else if (byte_end) begin
      crc_r <= crc_nxt;
      lrc_r <= lrc_nxt;
    end
  end

  // interrupt status, cleared by a read of itself; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r <= 3'h0;
      irq   <= 1'b0;
    end else begin
      ist_r <= ev | (ist_r & ~((rd_acc && sel_ist) ? rdat_r[2:0] : 3'h0));
      irq   <= |(ist_r & imask_r);
    end
  end

  // ----------------------------------------------------------------------------
  // link engine: half duplex, one etu counter shared by receive and transmit
  // ----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= CUF_IDLE;
      bit_r     <= 4'h0;
      etu_cnt_r <= 12'h000;
      shf_r     <= 8'h00;
      txs_r     <= 11'h7ff;
    end else begin
      unique case (st_r)
        CUF_IDLE: begin
          if (rx_go) begin
            // async: wait half an etu to land mid start bit; sync: first edge is data
            st_r      <= CUF_RX;
            bit_r     <= sync_m ? `CUF_IDX_DATA0 + 4'h1 : `CUF_IDX_START;
            shf_r     <= {io_s2_r, 7'h00};
            etu_cnt_r <= {1'b0, etu_r[11:1]};
          end else if (tx_go) begin
            st_r      <= CUF_TX;
            bit_r     <= 4'h0;
            etu_cnt_r <= etu_r - 12'h001;
            txs_r     <= sync_m ? {3'b111, txq.head} :
                         {1'b1, ^txq.head, txq.head, 1'b0};        // see R1
          end
        end
        CUF_RX: begin
          if (rise) etu_cnt_r <= etu_zero ? etu_r - 12'h001 : etu_cnt_r - 12'h001;
          // a start bit that reads high at its sample is noise: back to idle
          if (false_st || byte_end) begin
            st_r  <= CUF_IDLE;
          end else if (samp) begin
            bit_r <= bit_r + 4'h1;
            if (bit_r != `CUF_IDX_START && bit_r <= `CUF_IDX_DATA7)
              shf_r <= {io_s2_r, shf_r[7:1]};
          end
        end
        CUF_TX: begin
          // a stopped card clock holds the frame; there is no timeout here
          if (rise) etu_cnt_r <= etu_zero ? etu_r - 12'h001 : etu_cnt_r - 12'h001;
          if (tick) begin
            txs_r <= {1'b1, txs_r[10:1]};
            bit_r <= bit_r + 4'h1;
            if (bit_r + 4'h1 == tx_bits) st_r <= CUF_IDLE;
          end
        end
        default: st_r <= CUF_IDLE;
      endcase
    end
  end

  // open drain io: pull low only for a zero bit while sending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_card_io_out  <= 1'b0;
      ext_card_io_oe_n <= 1'b1;
    end else begin
      ext_card_io_out  <= 1'b0;
      ext_card_io_oe_n <= !((st_r == CUF_TX) && !txs_r[0]);
    end
  end
endmodule : cuf_uart
`default_nettype wire

// file: sim/cuf_uart_sva.sv
// cuf_uart_sva.sv: port checks on the smart card uart top.
// assumes: bound to cuf_uart; apb answers one cycle after setup.
`timescale 1ns/1ps
`default_nettype none
`include "cuf_regs.svh"
module cuf_uart_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        card_clk,
  input wire logic        ext_card_io_in,
  input wire logic        ext_card_io_out,
  input wire logic        ext_card_io_oe_n,
  input wire logic        irq
);
  // ----------------------------------------------------------------
  // decode and sequences
  // ----------------------------------------------------------------
  // indices are sparse, so each one is listed
  wire logic [15:0] idx_w = paddr[17:2];
  wire logic mapped_w = idx_w inside {`CUF_IDX_TX_DATA, `CUF_IDX_RX_STAT,
    `CUF_IDX_RX_DATA, `CUF_IDX_CTRL, `CUF_IDX_ETU, `CUF_IDX_IRQ_STAT, `CUF_IDX_IRQ_MASK};
  wire logic byte_reg_w = idx_w inside {`CUF_IDX_TX_DATA, `CUF_IDX_RX_STAT,
    `CUF_IDX_RX_DATA};
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_read_stat;
    s_setup ##0 (!pwrite && idx_w == `CUF_IDX_RX_STAT);
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_has_cause: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  a_unmapped_error: assert property (s_setup ##0 !mapped_w |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_no_error: assert property (s_setup ##0 mapped_w |=> !pslverr)
    else $error("mapped access refused");
  a_byte_wide_regs: assert property (
    s_setup ##0 (!pwrite && byte_reg_w) |=> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_full_not_empty: assert property (
    s_read_stat |=> !(prdata[`CUF_ST_FULL] && prdata[`CUF_ST_EMPTY]))
    else $error("queue full and empty together");
  a_data_holds: assert property (!$past(psel && !penable) |-> $stable(prdata))
    else $error("read data moved outside setup");
  a_io_open_drain: assert property (ext_card_io_out == 1'b0)
    else $error("io output driven high");
endmodule : cuf_uart_sva
bind cuf_uart cuf_uart_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .card_clk, .ext_card_io_in, .ext_card_io_out,
  .ext_card_io_oe_n, .irq);
`default_nettype wire

// file: sim/cuf_card_model.sv
// cuf_card_model.sv: behavioural card on the contact interface.
// assumes: etu register set to ETU; io line has a pull-up.
`timescale 1ns/1ps
`default_nettype none
module cuf_card_model #(
  parameter int ETU = 4
) (
  output var  logic card_clk,
  output var  logic card_io,
  input  wire logic io_sense
);
  // clock stands still and io is released between frames
  initial begin
    card_clk = 1'b0;
    card_io  = 1'b1;
  end
  // 64 ns card clock, only while a frame is sent
  task automatic tick(input int n);
    repeat (n) begin
      #32 card_clk = 1'b1;
      #32 card_clk = 1'b0;
    end
  endtask : tick
  // start, data lsb first, even parity (flipped on request), stop
  task automatic send_async(input logic [7:0] d, input logic bad);
    logic [10:0] f;
    f = {1'b1, ^d ^ bad, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      card_io = f[i];
      tick(ETU);
    end
  endtask : send_async
  // one bit per card clock rise, ninth bit last
  task automatic send_sync(input logic [8:0] b);
    for (int i = 0; i < 9; i++) begin
      card_io = b[i];
      tick(1);
    end
    card_io = 1'b1;
  endtask : send_sync
  // clock a sync byte out of the reader, lsb first; each bit read before its rise
  task automatic recv_sync(output logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      #32 d[i] = io_sense;
      card_clk = 1'b1;
      #32 card_clk = 1'b0;
    end
  endtask : recv_sync
endmodule : cuf_card_model
`default_nettype wire

// file: sim/tb.sv
// tb.sv: self-checking bench for the smart card uart data path.
// assumes: card model drives card clock and io; io has a pull-up.
`timescale 1ns/1ps
`default_nettype none
`include "cuf_regs.svh"
module tb;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, got;
  logic        pready, pslverr, card_clk, card_io, io_out, io_oe_n, irq, err;
  wire logic   io_line;
  int          failures, checks;
  logic [7:0]  rx8;
  // open drain: low when either party pulls
  assign io_line = card_io & (io_oe_n | io_out);
  cuf_uart u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .card_clk(card_clk), .ext_card_io_in(io_line),
    .ext_card_io_out(io_out), .ext_card_io_oe_n(io_oe_n), .irq(irq));
  cuf_card_model #(.ETU(4)) u_card (.card_clk(card_clk), .card_io(card_io),
    .io_sense(io_line));
  // ----------------------------------------------------------------
  // clock, watchdog and tasks
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // runs need about 34 us; a hang is cut at 200 us
  initial begin
    #200_000;
    failures++;
    give_verdict();
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // one apb transfer from the next rising edge; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    got = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask : wr
  task automatic rd(input logic [15:0] idx, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, idx, 32'h0);
    chk(got & m, e);
  endtask : rd
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr  = 18'h0_0000;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`CUF_IDX_RX_DATA, 32'h0, 32'hffff_ffff);
    rd(`CUF_IDX_RX_STAT, 32'h0, 32'hffff_fffb);
    wr(`CUF_IDX_TX_DATA, 32'h0000_00a5);
    wr(`CUF_IDX_TX_DATA, 32'h0000_003c);
    rd(`CUF_IDX_TX_DATA, 32'h0000_00a5, 32'hffff_ffff);
    rd(`CUF_IDX_TX_DATA, 32'h0000_003c, 32'hffff_ffff);
    // queue now empty: the wrapped head still holds the first byte
    rd(`CUF_IDX_TX_DATA, 32'h0000_00a5, 32'hffff_ffff);
    apb(1'b0, 16'hfe0a, 32'h0);
    chk({31'h0, err}, 32'h1);
    // fill the receive queue with stored-byte events masked
    wr(`CUF_IDX_ETU, 32'h0000_0004);
    for (int i = 0; i < `CUF_RX_DEPTH; i++)
      u_card.send_async(8'h10 + 8'(i), 1'b0);
    chk({31'h0, irq}, 32'h0);
    rd(`CUF_IDX_RX_STAT, 32'h0000_0008, 32'h0000_000f);
    wr(`CUF_IDX_IRQ_MASK, 32'h0000_0002);
    u_card.send_async(8'hee, 1'b0);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    rd(`CUF_IDX_RX_DATA, 32'h0000_0010, 32'h0000_00ff);
    u_card.send_async(8'h77, 1'b0);
    rd(`CUF_IDX_RX_STAT, 32'h0000_0002, 32'h0000_000f);
    rd(`CUF_IDX_RX_STAT, 32'h0000_0000, 32'h0000_000f);
    rd(`CUF_IDX_IRQ_STAT, 32'h0000_0002, 32'h0000_0002);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    for (int i = 1; i < `CUF_RX_DEPTH; i++)
      rd(`CUF_IDX_RX_DATA, 32'h10 + i, 32'h0000_00ff);
    rd(`CUF_IDX_RX_STAT, 32'h0000_0004, 32'h0000_000f);
    // lrc block end: matching last byte passes, a wrong one flags
    for (int k = 0; k < 2; k++) begin
      wr(`CUF_IDX_CTRL, 32'h0);
      wr(`CUF_IDX_RX_STAT, 32'h0);
      u_card.send_async(8'h5a, 1'b0);
      wr(`CUF_IDX_RX_STAT, 32'h0000_0020);
      u_card.send_async(k ? 8'h33 : 8'h5a, 1'b0);
      rd(`CUF_IDX_RX_STAT, k ? 32'h10 : 32'h0, 32'h0000_0010);
      rd(`CUF_IDX_RX_DATA, 32'h0000_005a, 32'h0000_00ff);
      rd(`CUF_IDX_RX_DATA, k ? 32'h33 : 32'h5a, 32'h0000_00ff);
    end
    wr(`CUF_IDX_CTRL, 32'h0);
    // the final flag is software's and stays set; only the check error goes
    rd(`CUF_IDX_RX_STAT, 32'h0000_0020, 32'h0000_0030);
    // sync nine-bit frames, ninth bit one then zero
    wr(`CUF_IDX_CTRL, 32'h0000_0006);
    for (int k = 0; k < 2; k++) begin
      u_card.send_sync({k == 0, 8'hc3});
      rd(`CUF_IDX_RX_STAT, k ? 32'h0 : 32'h80, 32'h0000_0080);
      rd(`CUF_IDX_RX_DATA, 32'h0000_00c3, 32'h0000_00ff);
    end
    // sync transmit: the card clocks the byte out and reads the line
    wr(`CUF_IDX_CTRL, 32'h0000_0003);
    wr(`CUF_IDX_TX_DATA, 32'h0000_0096);
    u_card.recv_sync(rx8);
    chk({24'h00_0000, rx8}, 32'h0000_0096);
    chk({31'h0, io_oe_n}, 32'h1);
    // parity failure last, so a stored bad byte disturbs nothing
    wr(`CUF_IDX_CTRL, 32'h0);
    u_card.send_async(8'h55, 1'b1);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    rd(`CUF_IDX_RX_STAT, 32'h0000_0001, 32'h0000_0003);
    rd(`CUF_IDX_RX_STAT, 32'h0, 32'h0000_0001);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
